/* rtl/chan_pin_logic.sv */
// pin synchroniser and capture edge detector for the timer channel
`timescale 1ns/1ps
`default_nettype none
module chan_pin_logic
   import tmr_ch_pkg::*;
(
   input wire logic clk_in, // timer clock
   input wire logic rst_in, // async reset, active high
   input wire logic pin_in, // raw timer pin level
   input wire logic [1:0] els_in, // edge/level select field
   input wire logic capture_in, // channel is in input capture mode
   output logic edge_out // selected active edge, one cycle
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } sync_t;

   sync_t st;
   sync_t next_st;
   logic rise;
   logic fall;

   always_comb begin
      next_st = st;
      next_st.meta = pin_in;
      next_st.sync = st.meta;
      next_st.last = st.sync;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise = st.sync & ~st.last;
   assign fall = ~st.sync & st.last;

   // edge decode per select field; field 00 releases the pin
   always_comb begin
      edge_out = 1'b0;
      if (capture_in) begin
         case (els_in)
            ELS_RISE_TOGGLE: edge_out = rise;
            ELS_FALL_CLEAR: edge_out = fall;
            ELS_BOTH_SET: edge_out = rise | fall;
            default: edge_out = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

/* rtl/timer_channel0.sv */
// timer channel 0: capture, compare, edge and centre PWM with byte bus
`timescale 1ns/1ps
`default_nettype none
// Function
// - capture edge sets the event flag
// - compare or edge PWM match sets flag
// - centre PWM sets flag on both matches
// - interrupt when flag and enable set
// - clear flag: read while set, write 0
// - new event restarts the clear sequence
// - writing 1 ignored; reset clears flag
// - interrupt enable bit 6, reset clear
// - mode B selects edge PWM
// - mode A picks capture or compare
// - select field 00 releases the pin
// - capture edge: rise, fall or both
// - compare pin: none, toggle, low, high
// - edge PWM high-true or low-true pulses
// - centre select forces centre PWM mode
// - value holds capture or compare value
// - capture read latches both bytes
// - status write unlatches read buffer
// - compare writes load after both bytes
// - status write drops pending byte
// - centre select means up/down counting
module timer_channel0
   import tmr_ch_pkg::*;
(
   input wire logic MCLK_IN, // timer clock, 125 MHz
   input wire logic SYS_RST_IN, // async reset, active high
   input wire logic [1:0] ADDR_IN, // register index
   input wire logic [7:0] WDATA_IN, // write data
   input wire logic WR_IN, // write strobe
   input wire logic RD_IN, // read strobe
   output logic [7:0] RDATA_OUT, // read data, cycle after strobe
   input wire logic [15:0] COUNT_IN, // shared counter value
   input wire logic COUNT_DOWN_IN, // counter is counting down
   input wire logic CENTER_SEL_IN, // shared centre-aligned select
   input wire logic PIN_IN, // timer pin input level
   output logic PIN_OUT, // timer pin output level
   output logic PIN_OE_OUT, // timer pin driven by channel
   output logic IRQ_OUT // channel interrupt request
);
   import tmr_ch_pkg::*;

   typedef struct packed {
      logic flag;
      logic arm;
      logic ie;
      logic msb;
      logic msa;
      logic [1:0] els;
      logic [15:0] value;
      logic rd_latched;
      logic rd_first_hi;
      logic [15:0] rd_buf;
      logic wr_hi;
      logic wr_lo;
      logic [15:0] wr_buf;
      logic pin_q;
      logic [15:0] prev_count;
      logic [7:0] rdata;
   } state_t;

   state_t st;
   state_t next_st;
   mode_t mode;
   logic edge_evt;
   logic count_step;
   logic match;
   logic wrap;
   logic chan_event;
   logic sc_wr;
   logic sc_rd;

   ////////////////////////////////////////////////////////////////////////
   // mode decode

   function automatic mode_t decode_mode(input logic center,
                                         input logic msb,
                                         input logic msa);
      mode_t m;
      m = MODE_CAPTURE;
      if (center) begin
         m = MODE_CENTER_PWM;
      end else if (msb) begin
         m = MODE_EDGE_PWM;
      end else if (msa) begin
         m = MODE_COMPARE;
      end else begin
         m = MODE_CAPTURE;
      end
      return m;
   endfunction

   function automatic logic [7:0] pick_byte(input logic [15:0] word,
                                            input logic high);
      return high ? word[15:8] : word[7:0];
   endfunction

   assign mode = decode_mode(CENTER_SEL_IN, st.msb, st.msa);

   chan_pin_logic u_pin (
      .clk_in(MCLK_IN),
      .rst_in(SYS_RST_IN),
      .pin_in(PIN_IN),
      .els_in(st.els),
      .capture_in(mode == MODE_CAPTURE),
      .edge_out(edge_evt)
   );

   ////////////////////////////////////////////////////////////////////////
   // match detection: once per new counter value

   assign count_step = (COUNT_IN != st.prev_count);
   assign match = count_step && (COUNT_IN == st.value);
   assign wrap = count_step && (COUNT_IN == COUNT_ZERO);
   assign sc_wr = WR_IN && (ADDR_IN == ADDR_STATUS_CONTROL);
   assign sc_rd = RD_IN && (ADDR_IN == ADDR_STATUS_CONTROL);

   always_comb begin
      chan_event = 1'b0;
      case (mode)
         MODE_CAPTURE: chan_event = edge_evt;
         MODE_COMPARE: chan_event = match;
         MODE_EDGE_PWM: chan_event = match;
         MODE_CENTER_PWM: chan_event = match;
         default: chan_event = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;
      next_st.rdata = BYTE_RST;
      next_st.prev_count = COUNT_IN;

      // register reads
      if (RD_IN) begin
         case (ADDR_IN)
            ADDR_STATUS_CONTROL: begin
               next_st.rdata = {st.flag, st.ie, st.msb, st.msa,
                                st.els, 2'b00};
               if (st.flag) begin
                  next_st.arm = 1'b1;
               end
            end
            ADDR_VALUE_HIGH, ADDR_VALUE_LOW: begin
               if (mode == MODE_CAPTURE) begin
                  if (!st.rd_latched) begin
                     next_st.rdata = pick_byte(st.value,
                                     ADDR_IN == ADDR_VALUE_HIGH);
                     next_st.rd_buf = st.value;
                     next_st.rd_latched = 1'b1;
                     next_st.rd_first_hi = (ADDR_IN == ADDR_VALUE_HIGH);
                  end else begin
                     next_st.rdata = pick_byte(st.rd_buf,
                                     ADDR_IN == ADDR_VALUE_HIGH);
                     if (st.rd_first_hi != (ADDR_IN == ADDR_VALUE_HIGH))
                     begin
                        next_st.rd_latched = 1'b0;
                     end
                  end
               end else begin
                  next_st.rdata = pick_byte(st.value,
                                  ADDR_IN == ADDR_VALUE_HIGH);
               end
            end
            default: next_st.rdata = BYTE_RST;
         endcase
      end

      // register writes
      if (WR_IN) begin
         case (ADDR_IN)
            ADDR_STATUS_CONTROL: begin
               if (st.arm && !WDATA_IN[FLAG_BIT]) begin
                  next_st.flag = 1'b0;
               end
               next_st.arm = 1'b0;
               next_st.ie = WDATA_IN[IE_BIT];
               next_st.msb = WDATA_IN[MSB_BIT];
               next_st.msa = WDATA_IN[MSA_BIT];
               next_st.els = WDATA_IN[ELS_HI_BIT:ELS_LO_BIT];
               next_st.rd_latched = 1'b0;
               next_st.wr_hi = 1'b0;
               next_st.wr_lo = 1'b0;
            end
            ADDR_VALUE_HIGH: begin
               if (mode == MODE_CAPTURE) begin
                  next_st.value[15:8] = WDATA_IN;
               end else if (st.wr_lo) begin
                  next_st.value = {WDATA_IN, st.wr_buf[7:0]};
                  next_st.wr_hi = 1'b0;
                  next_st.wr_lo = 1'b0;
               end else begin
                  next_st.wr_buf[15:8] = WDATA_IN;
                  next_st.wr_hi = 1'b1;
               end
            end
            ADDR_VALUE_LOW: begin
               if (mode == MODE_CAPTURE) begin
                  next_st.value[7:0] = WDATA_IN;
               end else if (st.wr_hi) begin
                  next_st.value = {st.wr_buf[15:8], WDATA_IN};
                  next_st.wr_hi = 1'b0;
                  next_st.wr_lo = 1'b0;
               end else begin
                  next_st.wr_buf[7:0] = WDATA_IN;
                  next_st.wr_lo = 1'b1;
               end
            end
            default: next_st.arm = st.arm;
         endcase
      end

      // capture of the counter; hardware wins over a software byte write
      if (mode == MODE_CAPTURE && edge_evt) begin
         next_st.value = COUNT_IN;
      end

      // a new event sets the flag and forces the clear to restart
      if (chan_event) begin
         next_st.flag = 1'b1;
         next_st.arm = 1'b0;
      end

      // pin actions
      case (mode)
         MODE_COMPARE: begin
            if (match) begin
               case (st.els)
                  ELS_RISE_TOGGLE: next_st.pin_q = ~st.pin_q;
                  ELS_FALL_CLEAR: next_st.pin_q = 1'b0;
                  ELS_BOTH_SET: next_st.pin_q = 1'b1;
                  default: next_st.pin_q = st.pin_q;
               endcase
            end
         end
         MODE_EDGE_PWM: begin
            // period start asserts the pulse, match ends it; match wins
            if (wrap) begin
               next_st.pin_q = ~st.els[0];
            end
            if (match) begin
               next_st.pin_q = st.els[0];
            end
         end
         MODE_CENTER_PWM: begin
            if (match && !COUNT_DOWN_IN) begin
               next_st.pin_q = st.els[0];
            end else if (match && COUNT_DOWN_IN) begin
               next_st.pin_q = ~st.els[0];
            end
         end
         default: next_st.pin_q = st.pin_q;
      endcase
   end

   always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign RDATA_OUT = st.rdata;
   assign PIN_OUT = st.pin_q;
   assign PIN_OE_OUT = (mode != MODE_CAPTURE) && (st.els != ELS_OFF);
   assign IRQ_OUT = st.flag && st.ie;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   property p_capture_flag;
      (mode == MODE_CAPTURE) && edge_evt |=> st.flag && !st.arm;
   endproperty
   a_capture_flag: assert property (p_capture_flag)
      else $error("capture edge did not set the flag");

   property p_compare_flag;
      (mode == MODE_COMPARE || mode == MODE_EDGE_PWM)
         && count_step && (COUNT_IN == st.value) |=> st.flag;
   endproperty
   a_compare_flag: assert property (p_compare_flag)
      else $error("compare match did not set the flag");

   property p_center_flag;
      (mode == MODE_CENTER_PWM) && match |=> st.flag;
   endproperty
   a_center_flag: assert property (p_center_flag)
      else $error("centre match did not set the flag");

   property p_irq;
      $rose(st.flag) && st.ie |-> IRQ_OUT;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised for enabled flag");

   property p_clear_needs_read;
      st.flag && !st.arm && !chan_event |=> st.flag;
   endproperty
   a_clear_needs_read: assert property (p_clear_needs_read)
      else $error("flag cleared without a prior read");

   property p_clear_sequence;
      sc_rd && st.flag && !chan_event ##1
         sc_wr && !WDATA_IN[FLAG_BIT] && !chan_event |=> !st.flag;
   endproperty
   a_clear_sequence: assert property (p_clear_sequence)
      else $error("read then write 0 did not clear the flag");

   property p_restart;
      sc_rd && st.flag ##1 chan_event ##1
         sc_wr && !WDATA_IN[FLAG_BIT] |=> st.flag;
   endproperty
   a_restart: assert property (p_restart)
      else $error("event between read and write was lost");

   property p_write_one;
      !st.flag && !chan_event && sc_wr && WDATA_IN[FLAG_BIT] |=> !st.flag;
   endproperty
   a_write_one: assert property (p_write_one)
      else $error("writing 1 changed the flag");

   property p_enable;
      sc_wr |=> st.ie == $past(WDATA_IN[IE_BIT]);
   endproperty
   a_enable: assert property (p_enable)
      else $error("interrupt enable not written");

   property p_release;
      st.els == ELS_OFF |-> !PIN_OE_OUT && !edge_evt;
   endproperty
   a_release: assert property (p_release)
      else $error("pin used while select field is 00");

   property p_compare_low;
      (mode == MODE_COMPARE) && (st.els == ELS_FALL_CLEAR) && match
         && !sc_wr |=> !PIN_OUT && PIN_OE_OUT;
   endproperty
   a_compare_low: assert property (p_compare_low)
      else $error("compare clear action not applied");

   property p_coherent_write;
      (mode != MODE_CAPTURE) && !CENTER_SEL_IN && WR_IN
         && (ADDR_IN == ADDR_VALUE_HIGH) && !st.wr_lo ##1
      (mode != MODE_CAPTURE) && WR_IN && (ADDR_IN == ADDR_VALUE_LOW)
         |=> st.value == {$past(st.wr_buf[15:8]), $past(WDATA_IN)};
   endproperty
   a_coherent_write: assert property (p_coherent_write)
      else $error("two byte write not loaded as one value");

   property p_abandon;
      sc_wr |=> !st.wr_hi && !st.wr_lo && !st.rd_latched;
   endproperty
   a_abandon: assert property (p_abandon)
      else $error("status write left a byte buffer pending");
endmodule
`default_nettype wire

/* shared/tmr_ch_pkg.sv */
// shared constants and types for timer channel 0 capture/compare
package tmr_ch_pkg;
   // register indices on the byte bus
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_VALUE_HIGH = 2'h1;
   localparam logic [1:0] ADDR_VALUE_LOW = 2'h2;
   // status/control field positions
   localparam int FLAG_BIT = 7;
   localparam int IE_BIT = 6;
   localparam int MSB_BIT = 5;
   localparam int MSA_BIT = 4;
   localparam int ELS_HI_BIT = 3;
   localparam int ELS_LO_BIT = 2;
   // edge/level select codes
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
   localparam logic [1:0] ELS_BOTH_SET = 2'h3;
   // reset values and the counter wrap value
   localparam logic [15:0] VALUE_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   // synchroniser depth seen by logic before the edge detector
   localparam int SYNC_STAGES = 2;
   // channel operating modes
   typedef enum logic [3:0] {
      MODE_CAPTURE = 4'b0001,
      MODE_COMPARE = 4'b0010,
      MODE_EDGE_PWM = 4'b0100,
      MODE_CENTER_PWM = 4'b1000
   } mode_t;
endpackage

/* verif/pin_partner.sv */
// outside source and load on the timer channel pin
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input wire logic ext_level_in, // level the outside source drives
   input wire logic pin_out_in, // channel output level
   input wire logic pin_oe_in, // channel drives the pin
   output logic pin_level_out // resolved pin level
);
   // the channel owns the pin while it drives, else the source does
   assign pin_level_out = pin_oe_in ? pin_out_in : ext_level_in;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking testbench for timer channel 0
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tmr_ch_pkg::*;
   logic mclk, sys_rst, wr, rd, count_down, center_sel, ext_level;
   logic pin, pin_out, pin_oe, irq;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, got;
   logic [15:0] count;
   int miscompares, check_count, cycles;

   timer_channel0 i_dut (.MCLK_IN(mclk), .SYS_RST_IN(sys_rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .COUNT_IN(count), .COUNT_DOWN_IN(count_down),
      .CENTER_SEL_IN(center_sel), .PIN_IN(pin), .PIN_OUT(pin_out),
      .PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));
   pin_partner i_pin (.ext_level_in(ext_level), .pin_out_in(pin_out),
      .pin_oe_in(pin_oe), .pin_level_out(pin));

   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] seen);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic seen);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
      @(negedge mclk);
   endtask

   // high then low value byte on back-to-back write strobes
   task automatic wr_pair(input logic [7:0] hi, input logic [7:0] lo);
      @(posedge mclk);
      addr <= ADDR_VALUE_HIGH;
      wdata <= hi;
      wr <= 1'h1;
      @(posedge mclk);
      addr <= ADDR_VALUE_LOW;
      wdata <= lo;
      @(posedge mclk);
      wr <= 1'h0;
      @(negedge mclk);
   endtask

   // status read, then the clearing write; evt puts a match between them
   task automatic fast_clear(input logic evt);
      @(posedge mclk);
      addr <= ADDR_STATUS_CONTROL;
      wdata <= 8'h5c;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      if (evt) begin
         count <= 16'h1234;
         @(posedge mclk);
      end
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
      @(negedge mclk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      @(negedge mclk);
      d = rdata;
   endtask

   task automatic rchk(input logic [1:0] a, input logic [7:0] exp,
                       input string name);
      rd_reg(a, got);
      chk(name, exp, got);
   endtask

   // counter steps to a new value; the edge after it sees the match
   task automatic step(input logic [15:0] v, input logic down);
      @(posedge mclk);
      count <= v;
      count_down <= down;
      @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      rchk(ADDR_STATUS_CONTROL, 8'h00, "status reset");
      rchk(ADDR_VALUE_HIGH, 8'h00, "value high reset");
      rchk(ADDR_VALUE_LOW, 8'h00, "value low reset");
      rchk(2'h3, 8'h00, "unmapped read");
      chk1("pin released at reset", 1'h0, pin_oe);
      $display("test reset done");
   endtask

   task automatic test_compare;
      wr_reg(ADDR_STATUS_CONTROL, 8'h94);
      wr_reg(ADDR_VALUE_HIGH, 8'h12);
      rchk(ADDR_VALUE_HIGH, 8'h00, "half written value");
      wr_reg(ADDR_VALUE_LOW, 8'h34);
      rchk(ADDR_VALUE_HIGH, 8'h12, "value high loaded");
      rchk(ADDR_VALUE_LOW, 8'h34, "value low loaded");
      step(16'h1233, 1'h0);
      step(16'h1234, 1'h0);
      chk1("pin toggled on match", 1'h1, pin_out);
      chk1("pin driven", 1'h1, pin_oe);
      rchk(ADDR_STATUS_CONTROL, 8'h94, "flag on match");
      for (int i = 3; i >= 2; i--) begin
         wr_reg(ADDR_STATUS_CONTROL, {4'h9, 2'(i), 2'h0});
         step(16'h0000, 1'h0);
         step(16'h1234, 1'h0);
         chk1("pin set or cleared", i[0], pin_out);
      end
      wr_reg(ADDR_STATUS_CONTROL, 8'h90);
      step(16'h0000, 1'h0);
      step(16'h1234, 1'h0);
      chk1("software compare pin", 1'h0, pin_oe);
      rchk(ADDR_STATUS_CONTROL, 8'h90, "software compare flag");
      $display("test compare done");
   endtask

   task automatic test_clear;
      wr_reg(ADDR_STATUS_CONTROL, 8'hdc);
      wr_reg(ADDR_STATUS_CONTROL, 8'h5c);
      chk1("irq with flag", 1'h1, irq);
      rchk(ADDR_STATUS_CONTROL, 8'hdc, "clear without read");
      wr_reg(ADDR_STATUS_CONTROL, 8'h5c);
      chk1("irq after clear", 1'h0, irq);
      rchk(ADDR_STATUS_CONTROL, 8'h5c, "flag cleared");
      step(16'h0000, 1'h0);
      step(16'h1234, 1'h0);
      chk1("irq on match cycle", 1'h1, irq);
      rchk(ADDR_STATUS_CONTROL, 8'hdc, "flag set again");
      step(16'h0000, 1'h0);
      step(16'h1234, 1'h0);
      wr_reg(ADDR_STATUS_CONTROL, 8'h5c);
      rchk(ADDR_STATUS_CONTROL, 8'hdc, "event during clear");
      wr_reg(ADDR_STATUS_CONTROL, 8'h5c);
      chk1("irq cleared", 1'h0, irq);
      step(16'h0000, 1'h0);
      step(16'h1234, 1'h0);
      fast_clear(1'h0);
      chk1("irq after back-to-back clear", 1'h0, irq);
      step(16'h0000, 1'h0);
      step(16'h1234, 1'h0);
      step(16'h0000, 1'h0);
      fast_clear(1'h1);
      chk1("irq kept by event", 1'h1, irq);
      rchk(ADDR_STATUS_CONTROL, 8'hdc, "flag kept by event");
      $display("test clear done");
   endtask

   task automatic test_abandon;
      wr_reg(ADDR_VALUE_HIGH, 8'hab);
      wr_reg(ADDR_STATUS_CONTROL, 8'h5c);
      wr_reg(ADDR_VALUE_LOW, 8'hcd);
      rchk(ADDR_VALUE_HIGH, 8'h12, "dropped byte");
      wr_reg(ADDR_VALUE_HIGH, 8'hab);
      rchk(ADDR_VALUE_HIGH, 8'hab, "value high after restart");
      rchk(ADDR_VALUE_LOW, 8'hcd, "value low after restart");
      wr_pair(8'h56, 8'h78);
      rchk(ADDR_VALUE_HIGH, 8'h56, "value high back to back");
      rchk(ADDR_VALUE_LOW, 8'h78, "value low back to back");
      wr_pair(8'hab, 8'hcd);
      $display("test abandon done");
   endtask

   task automatic test_pwm;
      wr_reg(ADDR_STATUS_CONTROL, 8'h28);
      step(16'h0000, 1'h0);
      chk1("high-true start", 1'h1, pin_out);
      step(16'habcd, 1'h0);
      chk1("high-true match", 1'h0, pin_out);
      rchk(ADDR_STATUS_CONTROL, 8'ha8, "edge pwm flag");
      wr_reg(ADDR_STATUS_CONTROL, 8'h34);
      step(16'h0000, 1'h0);
      chk1("low-true start", 1'h0, pin_out);
      step(16'habcd, 1'h0);
      chk1("low-true match", 1'h1, pin_out);
      rd_reg(ADDR_STATUS_CONTROL, got);
      @(posedge mclk);
      center_sel <= 1'h1;
      wr_reg(ADDR_STATUS_CONTROL, 8'h08);
      step(16'habcc, 1'h0);
      step(16'habcd, 1'h0);
      chk1("centre up match", 1'h0, pin_out);
      rchk(ADDR_STATUS_CONTROL, 8'h88, "centre up flag");
      wr_reg(ADDR_STATUS_CONTROL, 8'h08);
      step(16'habce, 1'h1);
      step(16'habcd, 1'h1);
      chk1("centre down match", 1'h1, pin_out);
      rchk(ADDR_STATUS_CONTROL, 8'h88, "centre down flag");
      @(posedge mclk);
      center_sel <= 1'h0;
      $display("test pwm done");
   endtask

   task automatic test_capture;
      wr_reg(ADDR_STATUS_CONTROL, 8'h0c);
      // let a switch-over edge land before clearing the flag
      repeat (6) @(posedge mclk);
      rd_reg(ADDR_STATUS_CONTROL, got);
      wr_reg(ADDR_STATUS_CONTROL, 8'h0c);
      @(posedge mclk);
      count <= 16'h0777;
      ext_level <= 1'h1;
      repeat (6) @(posedge mclk);
      rchk(ADDR_STATUS_CONTROL, 8'h8c, "capture flag");
      rchk(ADDR_VALUE_LOW, 8'h77, "captured low");
      @(posedge mclk);
      count <= 16'h0888;
      ext_level <= 1'h0;
      repeat (6) @(posedge mclk);
      rchk(ADDR_VALUE_HIGH, 8'h07, "latched high");
      rchk(ADDR_VALUE_HIGH, 8'h08, "relatched high");
      rchk(ADDR_VALUE_LOW, 8'h88, "relatched low");
      rchk(ADDR_VALUE_LOW, 8'h88, "latch again");
      @(posedge mclk);
      count <= 16'h0999;
      ext_level <= 1'h1;
      repeat (6) @(posedge mclk);
      wr_reg(ADDR_STATUS_CONTROL, 8'h0c);
      rchk(ADDR_VALUE_HIGH, 8'h09, "unlatched by status write");
      $display("test capture done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      sys_rst = 1'h1;
      wr = 1'h0;
      rd = 1'h0;
      addr = 2'h0;
      wdata = 8'h00;
      count = 16'h0000;
      count_down = 1'h0;
      center_sel = 1'h0;
      ext_level = 1'h0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'h0;
      test_reset();
      test_compare();
      test_clear();
      test_abandon();
      test_pwm();
      test_capture();
      tally_and_finish();
   end
endmodule
`default_nettype wire
